// ---- rtl/scm_ctrl_top.sv ----
/*
 Serial peripheral controller mode logic with an Avalon-MM register slave, a
 master shifter and a slave shifter on the remote serial clock. Assumes the
 bus master holds each request until waitrequest is sampled low.
*/
// What this block does
// - Control bit 4 selects clock phase, resets to 0, picks one of two formats.
// - Control bit 3 sets clock polarity: 0 idles low, 1 idles high; resets 0.
// - Control bit 2 selects role: 0 slave, 1 master; resets to 0.
// - Slave role in dual or quad mode flags an error and may interrupt.
// - Enable bit 1 at 0 tri-states all outputs and ignores slave inputs.
// - Enabled master drives clock and data idle; slave drives only when selected.
// - Enabled master starts a transfer as soon as transmit data is present.
// - Loopback bit 0 acts only in standard master mode; resets to 0.
// - Loopback feeds transmit output to receiver; external slave data is dropped.
// - Least-bit-first in dual or quad mode flags an error and may interrupt.
// - Dual or quad mode allows phase and polarity 00 or 11 only.
// - Loopback with non-standard lanes sets loopback error flag at bit 9.
// - Least-bit-first with dual or quad sets ordering error at bit 8.
// - Slave role with dual or quad sets slave-mode error at bit 7.
`timescale 1ns/1ns
`default_nettype none
module scm_ctrl_top (
   // Clock, reset, freeze
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   // Avalon-MM register slave
   input  wire logic [scm_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                       avs_read_in,
   input  wire logic                       avs_write_in,
   input  wire logic [scm_pkg::DATA_W-1:0] avs_writedata_in,
   output logic [scm_pkg::DATA_W-1:0]      avs_readdata_out,
   output logic                            avs_waitrequest_out,
   // Serial link, master side
   output logic                            sck_out,
   output logic                            sck_oe_out,
   output logic                            ss_n_out,
   output logic                            ss_oe_out,
   output logic                            lane_zero_line_out,
   output logic                            lane_zero_line_oe_out,
   input  wire logic                       lane_one_line_in,
   // Serial link, slave side
   input  wire logic                       link_clk_in,
   input  wire logic                       ss_n_in,
   input  wire logic                       lane_zero_line_in,
   output logic                            lane_one_line_out,
   output logic                            lane_one_line_oe_out,
   // Error interrupt
   output logic                            irq_out
);
   typedef enum logic [1:0] {
      SCM_IDLE  = 2'b00,
      SCM_SHIFT = 2'b01,
      SCM_DONE  = 2'b11
   } scm_state_e;

   scm_state_e                      state_q;
   logic [scm_pkg::CTL_W-1:0]       ctrl_q;
   logic [2:0]                      lcf_q;
   logic [scm_pkg::ERR_W-1:0]       ien_q;
   logic [scm_pkg::ERR_W-1:0]       err_q;
   logic [scm_pkg::ERR_W-1:0]       err_d;
   logic [scm_pkg::WORD_W-1:0]      txd_q;
   logic [scm_pkg::WORD_W-1:0]      rxd_q;
   logic [scm_pkg::WORD_W-1:0]      tx_sh_q;
   logic [scm_pkg::WORD_W-1:0]      rx_sh_q;
   logic [scm_pkg::WORD_W-1:0]      slv_word;
   logic [scm_pkg::DATA_W-1:0]      rd_d;
   logic [7:0]                      div_q;
   logic [4:0]                      edge_q;
   logic                            tx_full_q;
   logic                            rx_valid_q;
   logic                            wait_q;
   logic                            sck_q;
   logic                            mosi_q;
   logic [2:0]                      miso_sync_q;
   logic                            miso_q;
   logic [2:0]                      ss_sync_q;
   logic                            ss_act_q;
   logic [2:0]                      tog_sync_q;
   logic                            tog_acc_q;
   logic                            slv_tog;
   logic                            slv_miso;

   wire logic enable    = ctrl_q[scm_pkg::CTL_ENABLE];
   wire logic master    = ctrl_q[scm_pkg::CTL_MASTER];
   wire logic clock_phase_select      = ctrl_q[scm_pkg::CTL_CLOCK_PHASE_SELECT];
   wire logic clock_polarity_select      = ctrl_q[scm_pkg::CTL_CLOCK_POLARITY_SELECT];
   wire logic std_lanes = lcf_q[1:0] == scm_pkg::LANE_STD;
   wire logic lsb_first = lcf_q[scm_pkg::LCF_LSB_FIRST];
   wire logic loop_act  = ctrl_q[scm_pkg::CTL_LOOP] & master & std_lanes;
   wire logic req       = avs_read_in | avs_write_in;
   wire logic acc       = req & ~wait_q;
   wire logic wr_acc    = acc & avs_write_in;
   wire logic tick      = state_q == SCM_SHIFT && div_q == scm_pkg::SCK_HALF - 8'h01;
   wire logic samp_edge = edge_q[0] == clock_phase_select;
   wire logic rx_bit    = loop_act ? mosi_q : miso_q;
   wire logic start     = enable & master & tx_full_q & state_q == SCM_IDLE;
   wire logic slv_event = tog_sync_q[1] == tog_sync_q[2] && tog_sync_q[2] != tog_acc_q;

   scm_slave_shift u_slave (
      .link_clk_in   (link_clk_in),
      .rst_in        (rst_in),
      .ss_n_in       (ss_n_in),
      .mode_inv_in   (clock_polarity_select ^ clock_phase_select),
      .clock_phase_select_in       (clock_phase_select),
      .lsb_first_in  (lsb_first),
      .mosi_in       (lane_zero_line_in),
      .miso_out      (slv_miso),
      .tx_word_in    (txd_q),
      .rx_word_out   (slv_word),
      .rx_toggle_out (slv_tog)
   );

   // Illegal combinations in dual or quad lane mode.
   always_comb begin
      err_d                     = '0;
      err_d[scm_pkg::ERR_PHASE] = ~std_lanes & (clock_phase_select != clock_polarity_select);
      err_d[scm_pkg::ERR_SLAVE] = ~std_lanes & ~master;
      err_d[scm_pkg::ERR_LSB]   = ~std_lanes & lsb_first;
      err_d[scm_pkg::ERR_LOOP]  = ~std_lanes & ctrl_q[scm_pkg::CTL_LOOP];
   end

   always_comb begin
      rd_d = '0;
      case (avs_address_in)
         scm_pkg::OFS_CONTROL:  rd_d[scm_pkg::CTL_W-1:0] = ctrl_q;
         scm_pkg::OFS_STATUS: begin
            rd_d[scm_pkg::STS_ERR_HI:scm_pkg::STS_ERR_LO] = err_q;
            rd_d[scm_pkg::STS_BUSY]     = state_q != SCM_IDLE;
            rd_d[scm_pkg::STS_TX_FULL]  = tx_full_q;
            rd_d[scm_pkg::STS_RX_VALID] = rx_valid_q;
         end
         scm_pkg::OFS_RX_DATA:  rd_d[scm_pkg::WORD_W-1:0] = rxd_q;
         scm_pkg::OFS_TX_DATA:  rd_d[scm_pkg::WORD_W-1:0] = txd_q;
         scm_pkg::OFS_LANE_CFG: rd_d[2:0] = lcf_q;
         scm_pkg::OFS_IRQ_EN:   rd_d[scm_pkg::ERR_W-1:0] = ien_q;
         default:               rd_d = '0;
      endcase
   end

   // Every access waits exactly one cycle, so read data is always registered.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_q           <= 1'b1;
         avs_readdata_out <= '0;
      end else if (ce_in) begin
         wait_q <= ~(req & wait_q);
         if (req & wait_q) begin
            avs_readdata_out <= rd_d;
         end
      end
   end

   assign avs_waitrequest_out = wait_q;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= scm_pkg::CTL_RESET;
         lcf_q  <= scm_pkg::LCF_RESET;
         ien_q  <= scm_pkg::ERR_RESET;
         txd_q  <= '0;
      end else if (ce_in && wr_acc) begin
         case (avs_address_in)
            scm_pkg::OFS_CONTROL:  ctrl_q <= avs_writedata_in[scm_pkg::CTL_W-1:0];
            scm_pkg::OFS_LANE_CFG: lcf_q  <= avs_writedata_in[2:0];
            scm_pkg::OFS_IRQ_EN:   ien_q  <= avs_writedata_in[scm_pkg::ERR_W-1:0];
            scm_pkg::OFS_TX_DATA:  txd_q  <= avs_writedata_in[scm_pkg::WORD_W-1:0];
            default:               ctrl_q <= ctrl_q;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_q   <= scm_pkg::ERR_RESET;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         err_q   <= err_d;
         irq_out <= |(err_q & ien_q);
      end
   end

   // A new write wins over the start or slave frame that empties the buffer.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_full_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_acc && avs_address_in == scm_pkg::OFS_TX_DATA) begin
            tx_full_q <= 1'b1;
         end else if (start || (slv_event && enable && !master)) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // A finished word sets the flag even when a read clears it in the same cycle.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rxd_q      <= '0;
         rx_valid_q <= 1'b0;
      end else if (ce_in) begin
         if (state_q == SCM_DONE) begin
            rxd_q      <= rx_sh_q;
            rx_valid_q <= 1'b1;
         end else if (slv_event && enable && !master) begin
            rxd_q      <= slv_word;
            rx_valid_q <= 1'b1;
         end else if (acc && avs_read_in && avs_address_in == scm_pkg::OFS_RX_DATA) begin
            rx_valid_q <= 1'b0;
         end
      end
   end

   // Pin and cross-domain inputs pass three stages; a change counts once two agree.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         miso_sync_q <= '0;
         miso_q      <= 1'b0;
         ss_sync_q   <= 3'h7;
         ss_act_q    <= 1'b0;
         tog_sync_q  <= '0;
         tog_acc_q   <= 1'b0;
      end else if (ce_in) begin
         miso_sync_q <= {miso_sync_q[1:0], lane_one_line_in};
         ss_sync_q   <= {ss_sync_q[1:0], ss_n_in};
         tog_sync_q  <= {tog_sync_q[1:0], slv_tog};
         if (miso_sync_q[1] == miso_sync_q[2]) begin
            miso_q <= miso_sync_q[2];
         end
         if (ss_sync_q[1] == ss_sync_q[2]) begin
            ss_act_q <= ~ss_sync_q[2];
         end
         if (slv_event) begin
            tog_acc_q <= tog_sync_q[2];
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= SCM_IDLE;
         div_q   <= '0;
         edge_q  <= '0;
         tx_sh_q <= '0;
         rx_sh_q <= '0;
      end else if (ce_in) begin
         case (state_q)
            SCM_IDLE: begin
               div_q  <= '0;
               edge_q <= '0;
               if (start) begin
                  tx_sh_q <= txd_q;
                  state_q <= SCM_SHIFT;
               end
            end
            SCM_SHIFT: begin
               div_q <= tick ? 8'h00 : div_q + 8'h01;
               if (tick) begin
                  edge_q <= edge_q + 5'h01;
                  if (samp_edge) begin
                     rx_sh_q <= lsb_first ? {rx_bit, rx_sh_q[7:1]} : {rx_sh_q[6:0], rx_bit};
                  end else if (!(clock_phase_select && edge_q == 5'h00)) begin
                     tx_sh_q <= lsb_first ? tx_sh_q >> 1 : tx_sh_q << 1;
                  end
                  if (edge_q == scm_pkg::EDGE_LAST) begin
                     state_q <= SCM_DONE;
                  end
               end
               if (!enable || !master) begin
                  state_q <= SCM_IDLE;
               end
            end
            SCM_DONE: state_q <= SCM_IDLE;
            default:  state_q <= SCM_IDLE;
         endcase
      end
   end

   // Link outputs except the slave data line are registered so that enables and levels change together.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sck_q                 <= 1'b0;
         mosi_q                <= 1'b0;
         ss_n_out              <= 1'b1;
         sck_oe_out            <= 1'b0;
         ss_oe_out             <= 1'b0;
         lane_zero_line_oe_out <= 1'b0;
         lane_one_line_oe_out  <= 1'b0;
      end else if (ce_in) begin
         sck_q <= state_q == SCM_SHIFT ? sck_q ^ tick : clock_polarity_select;
         mosi_q <= state_q == SCM_SHIFT && (lsb_first ? tx_sh_q[0] : tx_sh_q[7]);
         ss_n_out              <= state_q == SCM_IDLE;
         sck_oe_out            <= enable & master;
         ss_oe_out             <= enable & master;
         lane_zero_line_oe_out <= enable & master;
         lane_one_line_oe_out  <= enable & ~master & ss_act_q;
      end
   end

   assign sck_out            = sck_q;
   assign lane_zero_line_out = mosi_q;
   assign lane_one_line_out  = slv_miso;

   a_phase_write: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && wr_acc && avs_address_in == scm_pkg::OFS_CONTROL
      |=> clock_phase_select == $past(avs_writedata_in[scm_pkg::CTL_CLOCK_PHASE_SELECT]))
      else $error("phase bit did not take the written value");
   a_idle_polarity: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && state_q == SCM_IDLE && $past(state_q) == SCM_IDLE ##1 ce_in |-> sck_out == $past(clock_polarity_select))
      else $error("serial clock not at idle level");
   a_role_slave: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && !master |=> !sck_oe_out && !ss_oe_out)
      else $error("slave role drives master outputs");
   a_tri_disabled: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && !enable |=> !sck_oe_out && !lane_zero_line_oe_out && !lane_one_line_oe_out)
      else $error("outputs driven while disabled");
   a_master_drive: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && enable && master |=> sck_oe_out && lane_zero_line_oe_out && ss_oe_out)
      else $error("enabled master not driving");
   a_start_data: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && start |=> state_q == SCM_SHIFT && (!tx_full_q || $past(wr_acc)))
      else $error("transfer did not start on ready data");
   a_loop_feed: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && loop_act && tick && samp_edge && !lsb_first |=> rx_sh_q[0] == $past(mosi_q))
      else $error("loopback bit not taken from transmit line");
   a_slave_err: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && !std_lanes && !master |=> err_q[scm_pkg::ERR_SLAVE])
      else $error("slave role error not flagged");
   a_lsb_err: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && $past(ce_in) && err_q[scm_pkg::ERR_LSB] |-> $past(!std_lanes && lsb_first))
      else $error("ordering error flag without cause");
   a_phase_err: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && !std_lanes && clock_phase_select != clock_polarity_select && ien_q[scm_pkg::ERR_PHASE] ##1 ce_in |=> irq_out)
      else $error("phase error did not interrupt");
   a_loop_err: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      ce_in && !std_lanes && ctrl_q[scm_pkg::CTL_LOOP] |=> err_q[scm_pkg::ERR_LOOP])
      else $error("loopback error not flagged");
endmodule : scm_ctrl_top
`default_nettype wire

// ---- pkg/scm_pkg.sv ----
/*
 Constants for the serial control mode block: register offsets, field positions,
 reset values, lane modes and the serial clock ratio. Assumes byte addresses on a
 32-bit Avalon-MM register bus.
*/
`default_nettype none
package scm_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          WORD_W        = 8;
   // Register byte offsets.
   localparam logic [7:0]  OFS_CONTROL   = 8'h60;
   localparam logic [7:0]  OFS_STATUS    = 8'h64;
   localparam logic [7:0]  OFS_TX_DATA   = 8'h68;
   localparam logic [7:0]  OFS_RX_DATA   = 8'h6c;
   localparam logic [7:0]  OFS_LANE_CFG  = 8'h70;
   localparam logic [7:0]  OFS_IRQ_EN    = 8'h74;
   // Control register fields.
   localparam int          CTL_LOOP      = 0;
   localparam int          CTL_ENABLE    = 1;
   localparam int          CTL_MASTER    = 2;
   localparam int          CTL_CLOCK_POLARITY_SELECT      = 3;
   localparam int          CTL_CLOCK_PHASE_SELECT      = 4;
   localparam int          CTL_W         = 5;
   localparam logic [4:0]  CTL_RESET     = 5'h00;
   // Lane configuration fields.
   localparam int          LCF_LSB_FIRST = 2;
   localparam logic [1:0]  LANE_STD      = 2'h0;
   localparam logic [2:0]  LCF_RESET     = 3'h0;
   // Status fields; error flags are listed phase, slave, lsb, loopback.
   localparam int          STS_RX_VALID  = 0;
   localparam int          STS_TX_FULL   = 1;
   localparam int          STS_BUSY      = 2;
   localparam int          STS_ERR_LO    = 6;
   localparam int          STS_ERR_HI    = 9;
   localparam int          ERR_PHASE     = 0;
   localparam int          ERR_SLAVE     = 1;
   localparam int          ERR_LSB       = 2;
   localparam int          ERR_LOOP      = 3;
   localparam int          ERR_W         = 4;
   localparam logic [3:0]  ERR_RESET     = 4'h0;
   // Serial clock: core cycles per half period, and edges per word.
   localparam logic [7:0]  SCK_HALF      = 8'h08;
   localparam logic [4:0]  EDGE_LAST     = 5'h0f;
   localparam logic [3:0]  BIT_LAST      = 4'h7;
endpackage : scm_pkg
`default_nettype wire

// ---- rtl/scm_slave_shift.sv ----
/*
 Slave-role shifter running on the serial clock that the remote master drives.
 Assumes the transmit word and mode inputs are held steady while select is low.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_slave_shift (
   // Link clock and resets
   input  wire logic                       link_clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ss_n_in,
   // Mode, quasi-static from the core domain
   input  wire logic                       mode_inv_in,
   input  wire logic                       clock_phase_select_in,
   input  wire logic                       lsb_first_in,
   // Serial data
   input  wire logic                       mosi_in,
   output logic                            miso_out,
   // Words
   input  wire logic [scm_pkg::WORD_W-1:0] tx_word_in,
   output logic [scm_pkg::WORD_W-1:0]      rx_word_out,
   output logic                            rx_toggle_out
);
   logic       [scm_pkg::WORD_W-1:0] sh_q;
   logic       [3:0]                 in_cnt_q;
   logic       [3:0]                 out_cnt_q;
   logic       [3:0]                 idx;
   wire logic                        samp_clk  = link_clk_in ^ mode_inv_in;
   wire logic                        frame_rst = rst_in | ss_n_in;

   // The frame ends on its own select, since the link clock stops between frames.
   always_ff @(posedge samp_clk or posedge frame_rst) begin
      if (frame_rst) begin
         sh_q     <= '0;
         in_cnt_q <= '0;
      end else begin
         sh_q     <= lsb_first_in ? {mosi_in, sh_q[7:1]} : {sh_q[6:0], mosi_in};
         in_cnt_q <= in_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge samp_clk or posedge rst_in) begin
      if (rst_in) begin
         rx_word_out   <= '0;
         rx_toggle_out <= 1'b0;
      end else if (!ss_n_in && in_cnt_q == scm_pkg::BIT_LAST) begin
         rx_word_out   <= lsb_first_in ? {mosi_in, sh_q[7:1]} : {sh_q[6:0], mosi_in};
         rx_toggle_out <= ~rx_toggle_out;
      end
   end

   always_ff @(negedge samp_clk or posedge frame_rst) begin
      if (frame_rst) begin
         out_cnt_q <= '0;
      end else begin
         out_cnt_q <= out_cnt_q + 4'h1;
      end
   end

   // With the second phase the first shifting edge only presents bit zero.
   assign idx      = out_cnt_q - {3'h0, clock_phase_select_in};
   assign miso_out = lsb_first_in ? tx_word_in[idx[2:0]] : tx_word_in[3'h7 - idx[2:0]];
endmodule : scm_slave_shift
`default_nettype wire

// ---- tb/scm_flash_model.sv ----
/*
 Behavioural serial flash standing on the master link, clock mode 0 only.
 Assumes select is low for whole 8-bit frames and no pull on the data out line.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_flash_model #(
   parameter logic [7:0] REPLY = 8'h3c
) (
   // Serial link
   input  wire logic       sck_in,
   input  wire logic       ss_n_in,
   input  wire logic       mosi_in,
   output logic            miso_out,
   // Word taken in
   output logic [7:0]      rx_out
);
   logic [7:0] sh = 8'h00;
   initial miso_out = 1'b0;
   initial rx_out = 8'h00;
   always @(negedge ss_n_in) begin
      sh = REPLY;
      miso_out = REPLY[7];
   end
   always @(posedge sck_in) if (!ss_n_in) rx_out = {rx_out[6:0], mosi_in};
   always @(negedge sck_in) if (!ss_n_in) begin
      sh = {sh[6:0], 1'b0};
      miso_out = sh[7];
   end
   // A released line has no pull, so it shows the inverse rather than a stale bit.
   always @(posedge ss_n_in) miso_out = ~miso_out;
endmodule : scm_flash_model
`default_nettype wire

// ---- tb/test_spi_control_mode_bits.sv ----
/*
 Bench for scm_ctrl_top: control bits, master, loopback and slave frames, error flags.
 Assumes the flash model on the master link and a link clock made here in frames.
*/
`timescale 1ns/1ns
`default_nettype none
module test_spi_control_mode_bits;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, lclk = 0, ssn = 1, sdi = 0;
   logic [7:0]  adr = 8'h00, mrx, sb;
   logic [31:0] wd = 32'h0, rdq, q;
   logic        sck, sck_oe, ss_n, ss_oe, mosi, mosi_oe, miso, s_out, s_oe, irq, wt;
   int          n_fail = 0, checked = 0, cyc = 0, i;
   logic [4:0]  ec [6] = '{5'h06, 5'h02, 5'h06, 5'h0e, 5'h1e, 5'h07};
   logic [2:0]  el [6] = '{3'h1, 3'h2, 3'h5, 3'h1, 3'h2, 3'h1};
   logic [3:0]  ee [6] = '{4'h0, 4'h2, 4'h4, 4'h1, 4'h0, 4'h8};
   scm_ctrl_top uut (.core_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdq),
      .avs_waitrequest_out(wt), .sck_out(sck), .sck_oe_out(sck_oe), .ss_n_out(ss_n),
      .ss_oe_out(ss_oe), .lane_zero_line_out(mosi), .lane_zero_line_oe_out(mosi_oe),
      .lane_one_line_in(miso), .link_clk_in(lclk), .ss_n_in(ssn), .lane_zero_line_in(sdi),
      .lane_one_line_out(s_out), .lane_one_line_oe_out(s_oe), .irq_out(irq));
   scm_flash_model fm (.sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
      .rx_out(mrx));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         summarize();
      end
   end
   task summarize;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // The request is held until waitrequest is seen low at a rising edge.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdq;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask : rdchk
   task wait_rx;
      for (int k = 0; k < 100; k++) begin
         bus(1'b0, scm_pkg::OFS_STATUS, 32'h0);
         if (q[0] === 1'b1) break;
      end
   endtask : wait_rx
   task frame(input logic [7:0] b);
      #3 ssn = 1'b0;
      #120;
      for (int k = 7; k >= 0; k--) begin
         sdi = b[k];
         #40 sb = {sb[6:0], s_out};
         lclk = 1'b1;
         #40 lclk = 1'b0;
      end
      chk("slave oe", 32'h1, {31'h0, s_oe});
      #40 ssn = 1'b1;
   endtask : frame
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("oe at reset", 32'h0, {sck_oe, ss_oe, mosi_oe, s_oe});
      rdchk(scm_pkg::OFS_CONTROL, 32'hffffffff, 32'h0, "ctl reset");
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h1d);
      rdchk(scm_pkg::OFS_CONTROL, 32'h1f, 32'h1d, "ctl rw");
      repeat (4) @(negedge clk);
      chk("oe disabled", 32'h0, {sck_oe, mosi_oe, s_oe});
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h0e);
      repeat (4) @(negedge clk);
      chk("sck idle high", 32'h3, {sck_oe, sck});
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h06);
      repeat (4) @(negedge clk);
      chk("idle master", 32'hb, {sck_oe, sck, mosi_oe, ss_n});
      bus(1'b1, scm_pkg::OFS_TX_DATA, 32'ha5);
      wait_rx();
      rdchk(scm_pkg::OFS_RX_DATA, 32'hff, 32'h3c, "master rx");
      chk("flash rx", 32'ha5, {24'h0, mrx});
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h07);
      bus(1'b1, scm_pkg::OFS_TX_DATA, 32'h5a);
      wait_rx();
      rdchk(scm_pkg::OFS_RX_DATA, 32'hff, 32'h5a, "loop rx");
      bus(1'b1, scm_pkg::OFS_IRQ_EN, 32'hf);
      for (i = 0; i < 6; i++) begin
         bus(1'b1, scm_pkg::OFS_CONTROL, {27'h0, ec[i]});
         bus(1'b1, scm_pkg::OFS_LANE_CFG, {29'h0, el[i]});
         rdchk(scm_pkg::OFS_STATUS, 32'h3c0, {22'h0, ee[i], 6'h0}, "err flags");
         chk("irq", {31'h0, ee[i] != 4'h0}, {31'h0, irq});
      end
      bus(1'b1, scm_pkg::OFS_LANE_CFG, 32'h0);
      bus(1'b1, 8'h00, 32'hffffffff);
      rdchk(8'h00, 32'hffffffff, 32'h0, "unmapped");
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h02);
      bus(1'b1, scm_pkg::OFS_TX_DATA, 32'hc3);
      frame(8'h96);
      chk("slave tx", 32'hc3, {24'h0, sb});
      wait_rx();
      rdchk(scm_pkg::OFS_RX_DATA, 32'hff, 32'h96, "slave rx");
      bus(1'b1, scm_pkg::OFS_CONTROL, 32'h0);
      ssn <= 1'b0;
      repeat (8) @(negedge clk);
      chk("oe off selected", 32'h0, {sck_oe, ss_oe, mosi_oe, s_oe});
      ssn <= 1'b1;
      summarize();
   end
endmodule : test_spi_control_mode_bits
`default_nettype wire
